// ---- adc_serial_port_mode_select_bench.sv ----
// Testbench for the result port mode select block
`timescale 1ns/1ns
`include "aspm_defs.vh"
module adc_serial_port_mode_select_bench;
  reg         hclk, hresetn, hsel, hwrite, sps;
  reg  [31:0] haddr, hwdata;
  reg  [1:0]  htrans;
  reg  [2:0]  hsize;
  reg  [5:0]  host_pins;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, sclk_i, sclk_o, sclk_oe, cs_n, rd_n;
  wire        sdo, sdo_oe, fs, fs_oe, sdo_pin;
  wire [5:0]  shared_i, shared_o, shared_oe;
  wire        hready = hreadyout;
  integer     n_errors, comparisons;
  reg  [31:0] d;
  reg  [15:0] w;
  reg         ok, c;

  // Shared pins resolve between the block and the host straps
  assign shared_i = (shared_oe & shared_o) | (~shared_oe & host_pins);
  // An undriven data pin reads inverted, so a missing enable is caught
  assign sdo_pin = sdo_oe ? sdo : ~sdo;

  aspm_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .serial_parallel_select(sps), .shared_i(shared_i),
    .shared_o(shared_o), .shared_oe(shared_oe), .sclk_i(sclk_i),
    .sclk_o(sclk_o), .sclk_oe(sclk_oe), .serial_data_output(sdo),
    .serial_data_output_oe(sdo_oe), .frame_sync_o(fs),
    .frame_sync_oe(fs_oe), .cs_n(cs_n), .rd_n(rd_n));
  aspm_host HOST (.hclk(hclk), .sclk_o(sclk_o), .serial_data_output(sdo_pin),
    .frame_sync_o(fs), .sclk_i(sclk_i), .cs_n(cs_n), .rd_n(rd_n));

  initial begin
    hclk = 1'h0;
    forever #50 hclk = ~hclk;
  end

  task close_out;
    begin
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  task check(input string what, input [31:0] e, input [31:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("wrong value %s expected %h seen %h", what, e, g);
      end
    end
  endtask

  task ahb(input wr, input [7:0] a, input [31:0] wd, output [31:0] rd);
    integer t;
    begin
      t = 0;
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      @(posedge hclk);
      while (hready !== 1'h1 && t < 100) begin
        @(posedge hclk);
        t = t + 1;
      end
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'h1 && t < 100) begin
        @(posedge hclk);
        t = t + 1;
      end
      rd = hrdata;
      if (t >= 100) begin
        n_errors = n_errors + 1;
        close_out;
      end
    end
  endtask

  task wr(input [7:0] a, input [31:0] v);
    reg [31:0] x;
    begin
      ahb(1'h1, a, v, x);
    end
  endtask

  task rdchk(input string what, input [7:0] a, input [31:0] m,
             input [31:0] e);
    reg [31:0] x;
    begin
      ahb(1'h0, a, 32'h00000000, x);
      check(what, e, x & m);
    end
  endtask

  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    hwrite = 1'h0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'h0;
    hsize = 3'h2;
    sps = 1'h0;
    host_pins = 6'h00;
    n_errors = 0;
    comparisons = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rdchk("ctrl reset", `ASPM_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    wr(`ASPM_OFS_DATA, 32'hFFFFA5C3);
    repeat (8) @(posedge hclk);
    check("par bits", 32'h30, {26'h0, shared_o});
    check("par oe", 32'h3F, {26'h0, shared_oe});
    check("par ctl", 32'h5, {29'h0, fs, sclk_o, sdo});
    rdchk("unmapped", 8'h0C, 32'hFFFFFFFF, 32'h0);
    rdchk("stat par", `ASPM_OFS_STAT, 32'h181, 32'h100);
    wr(`ASPM_OFS_CTRL, 32'h1);
    rdchk("ctrl busy", `ASPM_OFS_CTRL, 32'h1, 32'h1);
    // Master read-after-convert, divider code one
    host_pins <= 6'h01;
    sps <= 1'h1;
    repeat (8) @(posedge hclk);
    rdchk("stat rac", `ASPM_OFS_STAT, 32'h7F, 32'h21);
    check("ser oe", 32'h0, {26'h0, shared_oe});
    wr(`ASPM_OFS_DATA, 32'h1234);
    repeat (80) @(posedge hclk);
    rdchk("held busy", `ASPM_OFS_STAT, 32'h80, 32'h80);
    wr(`ASPM_OFS_CTRL, 32'h0);
    HOST.master_get(1'h0, 1'h0, w, ok);
    check("master rac", 32'h11234, {15'h0, ok, w});
    // Read during convert, inverted sync and clock, divider pins ignored
    repeat (40) @(posedge hclk);
    host_pins <= 6'h3A;
    wr(`ASPM_OFS_DATA, 32'hBEEF);
    repeat (80) @(posedge hclk);
    rdchk("held idle", `ASPM_OFS_STAT, 32'hE0, 32'hA0);
    wr(`ASPM_OFS_CTRL, 32'h1);
    HOST.master_get(1'h1, 1'h1, w, ok);
    check("master rdc", 32'h1BEEF, {15'h0, ok, w});
    // Slave with chaining: fill the buffer, then drain it
    repeat (40) @(posedge hclk);
    host_pins <= 6'h24;
    wr(`ASPM_OFS_DATA, 32'h8001);
    wr(`ASPM_OFS_DATA, 32'h7FFE);
    repeat (8) @(posedge hclk);
    rdchk("buf full", `ASPM_OFS_STAT, 32'h180, 32'h80);
    HOST.slave_get(1'h0, w, c);
    check("slave w1", 32'h18001, {15'h0, c, w});
    host_pins <= 6'h1C;
    HOST.slave_get(1'h1, w, c);
    check("slave w2", 32'h07FFE, {15'h0, c, w});
    repeat (8) @(posedge hclk);
    rdchk("buf empty", `ASPM_OFS_STAT, 32'h180, 32'h100);
    close_out;
  end
endmodule

// ---- aspm_buf.v ----
// Two-entry result buffer with valid/ready on both sides
`timescale 1ns/1ns
`include "aspm_defs.vh"

module aspm_buf #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input  wire             hclk,
  input  wire             hresetn,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_ff [0:`ASPM_BUF_DEPTH-1];
  reg [1:0]       count_ff;
  reg             wptr_ff;
  reg             rptr_ff;
  wire            push;
  wire            pop;

  assign in_ready  = (count_ff != 2'h2);
  assign out_valid = (count_ff != 2'h0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_ff  <= 2'h0;
      wptr_ff   <= 1'b0;
      rptr_ff   <= 1'b0;
      mem_ff[0] <= {WIDTH{1'b0}};
      mem_ff[1] <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem_ff[wptr_ff] <= in_data;
        wptr_ff         <= ~wptr_ff;
      end
      if (pop)
        rptr_ff <= ~rptr_ff;
      if (push & ~pop)
        count_ff <= count_ff + 2'h1;
      else if (pop & ~push)
        count_ff <= count_ff - 2'h1;
    end
  end

  // Head word is read straight from the entry flops; a write into an
  // empty buffer shows here on the same edge that raises valid
  always @* begin
    out_data = mem_ff[rptr_ff];
  end

endmodule

// ---- aspm_clkdiv.v ----
// Tick generator that sets the internal serial clock rate
`timescale 1ns/1ns
`include "aspm_defs.vh"

module aspm_clkdiv (
  // Clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // Control
  input  wire       en,
  input  wire [1:0] code,
  // Rate pulse
  output reg        tick
);

  reg  [2:0] cnt_ff;
  wire [2:0] limit;

  // Code 0 ticks every cycle, each higher code halves the rate
  assign limit = (3'h1 << code) - 3'h1;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 3'h0;
      tick   <= 1'b0;
    end else if (!en) begin
      cnt_ff <= 3'h0;
      tick   <= 1'b0;
    end else if (cnt_ff >= limit) begin
      cnt_ff <= 3'h0;
      tick   <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 3'h1;
      tick   <= 1'b0;
    end
  end

endmodule

// ---- aspm_defs.vh ----
// Shared constants for the converter result port mode logic
`ifndef ASPM_DEFS_VH
`define ASPM_DEFS_VH

// Register byte offsets (haddr[7:0])
`define ASPM_OFS_CTRL       8'h00
`define ASPM_OFS_DATA       8'h04
`define ASPM_OFS_STAT       8'h08

// Control register fields
`define ASPM_CTRL_BUSY_BIT  0

// Reset values
`define ASPM_RST_BUSY       1'b0
`define ASPM_RST_DIV        2'h0
`define ASPM_RST_WORD       16'h0000

// Shared pin positions within the D2..D7 group
`define ASPM_PIN_DIV_LO     0
`define ASPM_PIN_DIV_HI     1
`define ASPM_PIN_CLK_SRC    2
`define ASPM_PIN_SYNC_POL   3
`define ASPM_PIN_CLK_INV    4
`define ASPM_PIN_RDMODE     5

// Serial frame timing
`define ASPM_WORD_BITS      16
`define ASPM_LAST_BIT       5'h0F
`define ASPM_CHAIN_DELAY    16

// Buffer
`define ASPM_BUF_DEPTH      2

`endif

// ---- aspm_host.sv ----
// Host model that reads results over the serial port
`timescale 1ns/1ns
module aspm_host (
  // Clock
  input  wire hclk,
  // Serial port seen from the host
  input  wire sclk_o,
  input  wire serial_data_output,
  input  wire frame_sync_o,
  output reg  sclk_i,
  output reg  cs_n,
  output reg  rd_n
);
  initial begin
    sclk_i = 1'h0;
    cs_n   = 1'h1;
    rd_n   = 1'h1;
  end

  // Master: sample on each rising internal clock while sync is active
  task master_get(input pol, input inv, output [15:0] w, output ok);
    integer t;
    integer n;
    reg     prev;
    begin
      w = 16'h0000;
      n = 0;
      // The data pin is only enabled while chip select and read are low
      cs_n <= 1'h0;
      rd_n <= 1'h0;
      prev = sclk_o ^ inv;
      for (t = 0; t < 400 && n < 16; t = t + 1) begin
        @(posedge hclk);
        if ((frame_sync_o ^ pol) && (sclk_o ^ inv) && !prev) begin
          w = {w[14:0], serial_data_output};
          n = n + 1;
        end
        prev = sclk_o ^ inv;
      end
      ok = (n == 16);
      cs_n <= 1'h1;
      rd_n <= 1'h1;
    end
  endtask

  // Slave: stray edges with chip select high first, they must be ignored
  task slave_get(input inv, output [15:0] w, output chain);
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        repeat (3) @(posedge hclk);
        sclk_i <= ~sclk_i;
      end
      @(posedge hclk);
      sclk_i <= inv;
      repeat (4) @(posedge hclk);
      cs_n <= 1'h0;
      rd_n <= 1'h0;
      repeat (8) @(posedge hclk);
      w = {15'h0000, serial_data_output};
      for (k = 0; k < 16; k = k + 1) begin
        sclk_i <= ~inv;
        repeat (6) @(posedge hclk);
        sclk_i <= inv;
        if (k < 15)
          w = {w[14:0], serial_data_output};
        else
          chain = serial_data_output;
        repeat (6) @(posedge hclk);
      end
      cs_n <= 1'h1;
      rd_n <= 1'h1;
    end
  endtask
endmodule

// ---- aspm_top.v ----
// Result port mode select logic: parallel bits or strapped serial port
//
// What this block does
// - Select low drives parallel data bits 2 to 7 on the shared pins.
// - Divider pins are sampled only in serial master read-after-convert mode.
// - Other serial modes keep the divider pins at high impedance.
// - Clock source low: master drives the clock; high: slave takes it.
// - Slave shifts on external clock, ignored unless chip select asserted.
// - Sync polarity low gives active-high sync, high gives active-low.
// - Clock invert input inverts the serial clock in master and slave.
// - Dual pin is chain input when clock source high, else read mode.
// - Slave forwards chain input to data output 16 clocks after read start.
// - Master with read mode high shifts previous result during conversion.
// - Master with read mode low outputs result after conversion completes.
// - Select low picks parallel port, high reuses bus pins for serial.
// - Read with polarity low drives sync high while output data valid.
// - Slave updates data on rising edge, falling when clock invert high.
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "aspm_defs.vh"

module aspm_top (
  // AHB-Lite slave
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Port strap
  input  wire        serial_parallel_select,
  // Shared pins D2..D7
  input  wire [5:0]  shared_i,
  output reg  [5:0]  shared_o,
  output reg  [5:0]  shared_oe,
  // Serial clock pin (D9)
  input  wire        sclk_i,
  output reg         sclk_o,
  output reg         sclk_oe,
  // Serial data pin (D8)
  output reg         serial_data_output,
  output reg         serial_data_output_oe,
  // Frame sync pin (D10)
  output reg         frame_sync_o,
  output reg         frame_sync_oe,
  // Read strobes
  input  wire        cs_n,
  input  wire        rd_n
);

  localparam ST_IDLE  = 3'h1;
  localparam ST_SHIFT = 3'h2;
  localparam ST_CHAIN = 3'h4;

  // Pin synchronisers
  wire [9:0] raw_pins;
  reg  [9:0] meta_ff;
  reg  [9:0] sync_ff;

  assign raw_pins = {serial_parallel_select, cs_n, rd_n, sclk_i, shared_i};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= 10'h000;
      sync_ff <= 10'h000;
    end else begin
      meta_ff <= raw_pins;
      sync_ff <= meta_ff;
    end
  end

  wire [5:0] s_shared = sync_ff[5:0];
  wire       s_sclk   = sync_ff[6];
  wire       s_rd_n   = sync_ff[7];
  wire       s_cs_n   = sync_ff[8];
  wire       s_ser    = sync_ff[9];

  // Strap decode, meaningful only while the pins are inputs
  wire clock_source_select      = s_shared[`ASPM_PIN_CLK_SRC];
  wire frame_sync_polarity      = s_shared[`ASPM_PIN_SYNC_POL];
  wire serial_clock_invert      = s_shared[`ASPM_PIN_CLK_INV];
  wire read_mode_or_chain_input = s_shared[`ASPM_PIN_RDMODE];

  wire master  = s_ser & ~clock_source_select;
  wire slave   = s_ser & clock_source_select;
  wire rd_mode = master & read_mode_or_chain_input;
  wire chain_d = read_mode_or_chain_input;
  wire rac     = master & ~read_mode_or_chain_input;

  // Divider code follows the pins only in read-after-convert master mode
  reg [1:0] serial_clock_divider_ff;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      serial_clock_divider_ff <= `ASPM_RST_DIV;
    else if (rac)
      serial_clock_divider_ff <= s_shared[1:0];
  end

  // Bus slave state
  reg        dp_ff;
  reg        dp_wr_ff;
  reg [7:0]  dp_addr_ff;
  reg        busy_ff;

  // Buffer and frame state
  wire        buf_in_ready;
  wire        buf_out_valid;
  wire [15:0] buf_out_data;
  wire        buf_pop;
  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [15:0] shift_ff;
  reg  [15:0] nxt_shift;
  reg  [4:0]  bitcnt_ff;
  reg  [4:0]  nxt_bitcnt;
  reg         sclk_int_ff;
  reg         nxt_sclk_int;
  reg  [15:0] par_ff;
  reg         sclk_prev_ff;
  wire        tick;

  wire addr_take = hsel & htrans[1] & hready;
  wire dp_push   = dp_ff & dp_wr_ff & (dp_addr_ff == `ASPM_OFS_DATA);
  // A data write into a full buffer stalls the bus instead of dropping
  wire dp_done   = dp_ff & ~(dp_push & ~buf_in_ready);

  aspm_buf #(
    .WIDTH     (16)
  ) u_buf (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (dp_push),
    .in_ready  (buf_in_ready),
    .in_data   (hwdata[15:0]),
    .out_valid (buf_out_valid),
    .out_ready (buf_pop),
    .out_data  (buf_out_data)
  );

  aspm_clkdiv u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .en      (master & state_ff[1]),
    .code    (serial_clock_divider_ff),
    .tick    (tick)
  );

  // Register read mux
  reg [31:0] rd_val;

  always @* begin
    case (dp_addr_ff)
      `ASPM_OFS_CTRL: rd_val = {31'h0, busy_ff};
      `ASPM_OFS_STAT: rd_val = {21'h0, state_ff[2], state_ff[1],
                                buf_in_ready, buf_out_valid,
                                serial_clock_divider_ff,
                                read_mode_or_chain_input,
                                serial_clock_invert, frame_sync_polarity,
                                clock_source_select, s_ser};
      default:        rd_val = 32'h0;
    endcase
  end

  // At least one wait state on every transfer keeps hreadyout a flop
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_ff      <= 1'b0;
      dp_wr_ff   <= 1'b0;
      dp_addr_ff <= 8'h00;
      busy_ff    <= `ASPM_RST_BUSY;
      hreadyout  <= 1'b1;
      hrdata     <= 32'h0;
      hresp      <= 1'b0;
    end else if (addr_take) begin
      dp_ff      <= 1'b1;
      dp_wr_ff   <= hwrite;
      dp_addr_ff <= haddr[7:0];
      hreadyout  <= 1'b0;
    end else if (dp_done) begin
      dp_ff     <= 1'b0;
      hreadyout <= 1'b1;
      if (!dp_wr_ff)
        hrdata <= rd_val;
      else if (dp_addr_ff == `ASPM_OFS_CTRL)
        busy_ff <= hwdata[`ASPM_CTRL_BUSY_BIT];
    end
  end

  // Slave clock edges, only while chip select is low
  wire sclk_rise = s_sclk & ~sclk_prev_ff;
  wire sclk_fall = ~s_sclk & sclk_prev_ff;
  wire slave_upd = slave & ~s_cs_n &
                   (serial_clock_invert ? sclk_fall : sclk_rise);

  // Read start condition for each mode
  wire start_ok = master ? (rd_mode ? busy_ff : ~busy_ff)
                         : (~s_cs_n & ~s_rd_n);
  wire ser_pop  = state_ff[0] & s_ser & buf_out_valid & start_ok;
  wire par_pop  = ~s_ser & buf_out_valid;

  assign buf_pop = ser_pop | par_pop;

  always @* begin
    nxt_state    = state_ff;
    nxt_shift    = shift_ff;
    nxt_bitcnt   = bitcnt_ff;
    nxt_sclk_int = sclk_int_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_sclk_int = 1'b0;
        if (ser_pop) begin
          nxt_state  = ST_SHIFT;
          nxt_shift  = buf_out_data;
          nxt_bitcnt = 5'h00;
        end
      end
      ST_SHIFT: begin
        if (!s_ser) begin
          nxt_state = ST_IDLE;
        end else if (master) begin
          if (tick) begin
            nxt_sclk_int = ~sclk_int_ff;
            // Data moves at the end of each internal clock period
            if (sclk_int_ff) begin
              nxt_shift  = {shift_ff[14:0], 1'b0};
              nxt_bitcnt = bitcnt_ff + 5'h01;
              if (bitcnt_ff == `ASPM_LAST_BIT)
                nxt_state = ST_IDLE;
            end
          end
        end else if (s_cs_n) begin
          // Deasserted chip select abandons the word
          nxt_state = ST_IDLE;
        end else if (slave_upd) begin
          nxt_shift  = {shift_ff[14:0], 1'b0};
          nxt_bitcnt = bitcnt_ff + 5'h01;
          if (bitcnt_ff == `ASPM_LAST_BIT)
            nxt_state = ST_CHAIN;
        end
      end
      ST_CHAIN: begin
        if (!slave || s_cs_n)
          nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff     <= ST_IDLE;
      shift_ff     <= `ASPM_RST_WORD;
      bitcnt_ff    <= 5'h00;
      sclk_int_ff  <= 1'b0;
      sclk_prev_ff <= 1'b0;
      par_ff       <= `ASPM_RST_WORD;
    end else begin
      state_ff     <= nxt_state;
      shift_ff     <= nxt_shift;
      bitcnt_ff    <= nxt_bitcnt;
      sclk_int_ff  <= nxt_sclk_int;
      sclk_prev_ff <= s_sclk;
      if (par_pop)
        par_ff <= buf_out_data;
    end
  end

  // Pin drivers
  wire       frame_on  = state_ff[1];
  reg  [5:0] nxt_shared_o;
  reg  [5:0] nxt_shared_oe;
  reg        nxt_sclk_o;
  reg        nxt_sclk_oe;
  reg        nxt_sdo;
  reg        nxt_sdo_oe;
  reg        nxt_sync;

  always @* begin
    nxt_shared_o = par_ff[7:2];
    if (s_ser) begin
      // All shared pins are inputs, divider pair included
      nxt_shared_oe = 6'h00;
      nxt_sclk_oe   = master;
      nxt_sclk_o    = sclk_int_ff ^ serial_clock_invert;
      nxt_sdo       = state_ff[2] ? chain_d : shift_ff[15];
      nxt_sdo_oe    = ~s_cs_n & ~s_rd_n;
      nxt_sync      = frame_on ^ frame_sync_polarity;
    end else begin
      nxt_shared_oe = 6'h3F;
      nxt_sclk_oe   = 1'b1;
      nxt_sclk_o    = par_ff[9];
      nxt_sdo       = par_ff[8];
      nxt_sdo_oe    = 1'b1;
      nxt_sync      = par_ff[10];
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shared_o              <= 6'h00;
      shared_oe             <= 6'h00;
      sclk_o                <= 1'b0;
      sclk_oe               <= 1'b0;
      serial_data_output    <= 1'b0;
      serial_data_output_oe <= 1'b0;
      frame_sync_o          <= 1'b0;
      frame_sync_oe         <= 1'b0;
    end else begin
      shared_o              <= nxt_shared_o;
      shared_oe             <= nxt_shared_oe;
      sclk_o                <= nxt_sclk_o;
      sclk_oe               <= nxt_sclk_oe;
      serial_data_output    <= nxt_sdo;
      serial_data_output_oe <= nxt_sdo_oe;
      frame_sync_o          <= nxt_sync;
      frame_sync_oe         <= 1'b1;
    end
  end

endmodule

// ---- aspm_top_asserts.sv ----
// Checker for the result port pins and the bus answer timing
`timescale 1ns/1ns
module aspm_top_asserts (
  // Clock, reset and bus
  input wire       hclk,
  input wire       hresetn,
  input wire       hsel,
  input wire [1:0] htrans,
  input wire       hwrite,
  input wire       hready,
  input wire       hreadyout,
  input wire       hresp,
  // Port pins
  input wire       serial_parallel_select,
  input wire [5:0] shared_i,
  input wire [5:0] shared_oe,
  input wire       sclk_oe,
  input wire       serial_data_output_oe,
  input wire       frame_sync_o,
  input wire       frame_sync_oe,
  input wire       cs_n
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_read_taken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  // Pins pass two sync flops, the state flop and one output flop, so six samples settle
  sequence s_slave_idle(pol);
    (serial_parallel_select && shared_i[2] && cs_n && shared_i[3] == pol) [*6];
  endsequence

  a_read_answer: assert property (s_read_taken |=> s_answer)
    else $error("read answer not after two cycles");
  a_resp_okay: assert property (!hresp)
    else $error("error response seen");
  a_par_drive: assert property ((!serial_parallel_select) [*5] |->
    shared_oe == 6'h3F && sclk_oe && serial_data_output_oe && frame_sync_oe)
    else $error("parallel pins not driven");
  a_ser_float: assert property (serial_parallel_select [*5] |->
    shared_oe == 6'h00)
    else $error("shared pins driven in serial mode");
  a_master_clk: assert property (
    (serial_parallel_select && !shared_i[2]) [*5] |-> sclk_oe)
    else $error("master does not drive serial clock");
  a_slave_clk: assert property (
    (serial_parallel_select && shared_i[2]) [*5] |-> !sclk_oe)
    else $error("slave drives serial clock");
  a_data_gate: assert property (
    (serial_parallel_select && cs_n) [*5] |-> !serial_data_output_oe)
    else $error("data pin driven without chip select");
  a_sync_idle_hi: assert property (s_slave_idle(1'h1) |-> frame_sync_o)
    else $error("idle frame sync not high");
  a_sync_idle_lo: assert property (s_slave_idle(1'h0) |-> !frame_sync_o)
    else $error("idle frame sync not low");
endmodule

bind aspm_top aspm_top_asserts CHK (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp),
  .serial_parallel_select(serial_parallel_select), .shared_i(shared_i),
  .shared_oe(shared_oe), .sclk_oe(sclk_oe),
  .serial_data_output_oe(serial_data_output_oe),
  .frame_sync_o(frame_sync_o), .frame_sync_oe(frame_sync_oe), .cs_n(cs_n));
